// [common/host_port_pkg.sv]
package host_port_pkg;

  localparam int DATA_W = 16;
  localparam int WORD_W = 32;

  // register-select decode
  localparam logic [1:0] SEL_CTRL = 2'h0;
  localparam logic [1:0] SEL_ADDR = 2'h1;
  localparam logic [1:0] SEL_DATA_INC = 2'h2;
  localparam logic [1:0] SEL_DATA_FIX = 2'h3;

  localparam logic RW_READ = 1'h1;
  localparam logic HW_FIRST = 1'h0;

  // control register fields, written with the first half-word
  localparam int CTRL_DUAL_BIT = 3;
  localparam int CTRL_READ_COMMAND_A_BIT = 4;
  localparam logic [DATA_W-1:0] CTRL_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] CTRL_STORE_MASK = 16'hFFEF;

  localparam logic [WORD_W-1:0] ADDR_RESET = 32'h0000_0000;
  localparam logic [WORD_W-1:0] ADDR_STEP = 32'h0000_0004;

  // timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int PERIPH_CLK_DIV = 6;
  localparam int STROBE_GAP_PERIODS = 2;
  localparam int ADDR_SETTLE_NS = 40;
  localparam int ADDR_SETTLE_CYCLES = (ADDR_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_W = 4;
  localparam int SYNC_STAGES = 2;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_FALL,
    ST_HOLD,
    ST_RISE
  } port_state_t;

endpackage

// [rtl/host_pin_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module host_pin_sync #(
  parameter int DATA_W = 16
) (
  input wire logic clk_sys, // system clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic portSelectN, // chip select pin
  input wire logic dataStrobeAN, // data strobe a pin
  input wire logic dataStrobeBN, // data strobe b pin
  input wire logic [1:0] registerSelect, // register select pins
  input wire logic hostReadWrite, // direction pin, high reads
  input wire logic halfwordIdentifier, // half-word identifier pin
  input wire logic [DATA_W-1:0] hostDataIn, // host data bus input
  output logic csSyncN, // synchronised chip select
  output logic [1:0] selSync, // synchronised register select
  output logic rwSync, // synchronised direction
  output logic hwSync, // synchronised half-word identifier
  output logic [DATA_W-1:0] dataSync, // synchronised host data
  output logic strobeFall, // combined strobe went active
  output logic strobeRise // combined strobe went inactive
);

  localparam int PIN_W = DATA_W + 7;

  logic [PIN_W-1:0] stage1Reg;
  logic [PIN_W-1:0] stage2Reg;
  logic strobeNReg;
  logic strobeN;
  logic dsASync;
  logic dsBSync;

  // all pins share one latency so selects and data stay aligned with the strobe
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      stage1Reg <= '1;
      stage2Reg <= '1;
    end else begin
      stage1Reg <= {portSelectN, dataStrobeAN, dataStrobeBN, registerSelect, hostReadWrite,
                    halfwordIdentifier, hostDataIn};
      stage2Reg <= stage1Reg;
    end
  end

  assign csSyncN = stage2Reg[PIN_W-1];
  assign dsASync = stage2Reg[PIN_W-2];
  assign dsBSync = stage2Reg[PIN_W-3];
  assign selSync = stage2Reg[PIN_W-4:PIN_W-5];
  assign rwSync = stage2Reg[PIN_W-6];
  assign hwSync = stage2Reg[PIN_W-7];
  assign dataSync = stage2Reg[DATA_W-1:0];

  assign strobeN = ~(dsASync ^ dsBSync) | csSyncN;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      strobeNReg <= 1'b1;
    end else begin
      strobeNReg <= strobeN;
    end
  end

  assign strobeFall = strobeNReg & ~strobeN;
  assign strobeRise = ~strobeNReg & strobeN;

endmodule // host_pin_sync
`default_nettype wire

// [rtl/host_port_strobe_handshake.sv]
// Summary of operation
// - Combined strobe is active only when selected and exactly one data strobe low.
// - Register select, direction and half-word id captured when combined strobe falls.
// - Write data captured when the combined strobe rises.
// - Address writes stall when back-to-back, after read_command_a, or write FIFO not empty.
// - Data writes stall while write FIFO full or flushing; fixed-address second half also stalls after the rise.
// - Auto-increment data read stalls first half-word only when read FIFO empty.
// - Fixed-address data read stalls first half-word while the word is fetched.
// - Auto-increment read with data present keeps ready low on both halves.
// - Second half of fixed-address data read never stalls.
// - Control and address reads never stall.
// - Read data valid no later than ready goes low.
// - After write strobe rise: stall on FIFO full, address write while write FIFO not empty, fixed data second half.
// - Ready driven low whenever chip select is inactive.
// - Separate read and write address registers, shared or dual by control bit.
`timescale 1ns/1ps
`default_nettype none
module host_port_strobe_handshake #(
  parameter int DATA_W = host_port_pkg::DATA_W,
  parameter int WORD_W = host_port_pkg::WORD_W
) (
  input wire logic clk_sys, // system clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic portSelectN, // chip select pin
  input wire logic dataStrobeAN, // data strobe a pin
  input wire logic dataStrobeBN, // data strobe b pin
  input wire logic [1:0] registerSelect, // register select pins
  input wire logic hostReadWrite, // direction, high reads
  input wire logic halfwordIdentifier, // low on first half-word
  input wire logic [DATA_W-1:0] hostDataIn, // host data bus input
  output logic [DATA_W-1:0] hostDataOut, // host data bus output
  output logic hostDataOe, // host data bus drive enable
  output logic portReadyN, // ready pin, active low
  output logic memWrValid, // write word offered to write FIFO
  output logic [WORD_W-1:0] memWrAddr, // write word address
  output logic [WORD_W-1:0] memWrData, // write word
  input wire logic wrFifoFull, // write FIFO full
  input wire logic wrFifoFlushing, // write FIFO flushing
  input wire logic wrFifoEmpty, // write FIFO empty
  output logic memRdReq, // fixed-address fetch request
  output logic [WORD_W-1:0] memRdAddr, // read address
  input wire logic memRdAck, // fetch answered
  input wire logic [WORD_W-1:0] memRdData, // fetched word
  input wire logic rdFifoValid, // read FIFO has a word
  input wire logic [WORD_W-1:0] rdFifoData, // read FIFO head word
  output logic rdFifoPop, // read FIFO word consumed
  output logic prefetchReq, // read_command_a command pulse
  output logic dualAddrMode // separate read and write addresses
);

  logic csSyncN;
  logic [1:0] selSync;
  logic rwSync;
  logic hwSync;
  logic [DATA_W-1:0] dataSync;
  logic strobeFall;
  logic strobeRise;

  host_pin_sync #(
    .DATA_W(DATA_W)
  ) u_pin_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .portSelectN(portSelectN),
    .dataStrobeAN(dataStrobeAN),
    .dataStrobeBN(dataStrobeBN),
    .registerSelect(registerSelect),
    .hostReadWrite(hostReadWrite),
    .halfwordIdentifier(halfwordIdentifier),
    .hostDataIn(hostDataIn),
    .csSyncN(csSyncN),
    .selSync(selSync),
    .rwSync(rwSync),
    .hwSync(hwSync),
    .dataSync(dataSync),
    .strobeFall(strobeFall),
    .strobeRise(strobeRise)
  );

  host_port_pkg::port_state_t state_reg;
  host_port_pkg::port_state_t state_next;
  logic [1:0] sel_reg;
  logic rw_reg;
  logic hw_reg;
  logic [DATA_W-1:0] wrHalf_reg;
  logic [DATA_W-1:0] firstHalf_reg;
  logic [DATA_W-1:0] ctrl_reg;
  logic [WORD_W-1:0] writeAddr_reg;
  logic [WORD_W-1:0] readAddr_reg;
  logic [WORD_W-1:0] readWord_reg;
  logic [DATA_W-1:0] dataOut_reg;
  logic dataOe_reg;
  logic ready_n_reg;
  logic pushed_reg;
  logic read_command_a_reg;
  logic prefetchBusy_reg;
  logic [host_port_pkg::SETTLE_W-1:0] settle_reg;

  logic isRead;
  logic isFirst;
  logic isData;
  logic settleBusy;
  logic fallBlocked;
  logic riseDone;
  logic fallAct;
  logic commit;
  logic [DATA_W-1:0] readHalf;

  function automatic logic [DATA_W-1:0] halfOf(input logic [WORD_W-1:0] word, input logic first);
    halfOf = first ? word[DATA_W-1:0] : word[WORD_W-1:DATA_W];
  endfunction

  function automatic logic [WORD_W-1:0] setHalf(input logic [WORD_W-1:0] word, input logic first,
                                                input logic [DATA_W-1:0] half);
    setHalf = first ? {word[WORD_W-1:DATA_W], half} : {half, word[DATA_W-1:0]};
  endfunction

  // data registers share the upper select bit
  function automatic logic selIsData(input logic [1:0] sel);
    selIsData = (sel == host_port_pkg::SEL_DATA_INC) || (sel == host_port_pkg::SEL_DATA_FIX);
  endfunction

  assign isRead = (rw_reg == host_port_pkg::RW_READ);
  assign isFirst = (hw_reg == host_port_pkg::HW_FIRST);
  assign isData = selIsData(sel_reg);
  assign settleBusy = (settle_reg != '0);
  assign dualAddrMode = ctrl_reg[host_port_pkg::CTRL_DUAL_BIT];

  always_comb begin
    fallBlocked = 1'b0;
    if (!isRead) begin
      if (sel_reg == host_port_pkg::SEL_ADDR) begin
        fallBlocked = settleBusy || prefetchBusy_reg || !wrFifoEmpty;
      end else if (isData) begin
        fallBlocked = wrFifoFull || wrFifoFlushing;
      end
    // read FIFO decides first half only
    end else if (sel_reg == host_port_pkg::SEL_DATA_INC) begin
      fallBlocked = isFirst && !rdFifoValid;
    end else if (sel_reg == host_port_pkg::SEL_DATA_FIX) begin
      fallBlocked = isFirst && !memRdAck;
    end
  end

  // stall cases after the write strobe rises
  always_comb begin
    case (sel_reg)
      host_port_pkg::SEL_ADDR: riseDone = wrFifoEmpty;
      // push and finish in one cycle, so ready only rises on a full fifo
      host_port_pkg::SEL_DATA_INC: riseDone = isFirst ? !wrFifoFull : (pushed_reg || memWrValid);
      host_port_pkg::SEL_DATA_FIX: riseDone = isFirst ? !wrFifoFull : (pushed_reg && wrFifoEmpty);
      default: riseDone = 1'b1;
    endcase
  end

  assign fallAct = (state_reg == host_port_pkg::ST_FALL) && !fallBlocked && !strobeRise;
  assign commit = (state_reg == host_port_pkg::ST_RISE) && riseDone;
  assign memRdReq = (state_reg == host_port_pkg::ST_FALL) && isRead && isFirst &&
                    (sel_reg == host_port_pkg::SEL_DATA_FIX);
  assign rdFifoPop = fallAct && isRead && isFirst && (sel_reg == host_port_pkg::SEL_DATA_INC);
  assign memWrValid = (state_reg == host_port_pkg::ST_RISE) && isData && !isFirst &&
                      !pushed_reg && !wrFifoFull;

  always_comb begin
    case (sel_reg)
      host_port_pkg::SEL_CTRL: readHalf = isFirst ? ctrl_reg : '0;
      host_port_pkg::SEL_ADDR: readHalf = halfOf(readAddr_reg, isFirst);
      host_port_pkg::SEL_DATA_INC: readHalf = isFirst ? halfOf(rdFifoData, 1'b1) : halfOf(readWord_reg, 1'b0);
      default: readHalf = isFirst ? halfOf(memRdData, 1'b1) : halfOf(readWord_reg, 1'b0);
    endcase
  end

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      host_port_pkg::ST_IDLE: if (strobeFall) state_next = host_port_pkg::ST_FALL;
      host_port_pkg::ST_FALL: begin
        // host broke the handshake: drop the access
        if (strobeRise) state_next = host_port_pkg::ST_IDLE;
        else if (!fallBlocked) state_next = host_port_pkg::ST_HOLD;
      end
      host_port_pkg::ST_HOLD: begin
        if (strobeRise) state_next = isRead ? host_port_pkg::ST_IDLE : host_port_pkg::ST_RISE;
      end
      host_port_pkg::ST_RISE: if (riseDone) state_next = host_port_pkg::ST_IDLE;
      default: state_next = host_port_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) state_reg <= host_port_pkg::ST_IDLE;
    else state_reg <= state_next;
  end

  // selects captured at the falling strobe
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sel_reg <= host_port_pkg::SEL_CTRL;
      rw_reg <= host_port_pkg::RW_READ;
      hw_reg <= host_port_pkg::HW_FIRST;
    end else if (strobeFall && state_reg == host_port_pkg::ST_IDLE) begin
      sel_reg <= selSync;
      rw_reg <= rwSync;
      hw_reg <= hwSync;
    end
  end

  // write data taken at the rising strobe
  always_ff @(posedge clk_sys) begin
    if (!rst_n) wrHalf_reg <= '0;
    else if (strobeRise && state_reg == host_port_pkg::ST_HOLD && !isRead) wrHalf_reg <= dataSync;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) ready_n_reg <= 1'b0;
    else if (csSyncN) ready_n_reg <= 1'b0;
    // ready stays low unless a stall case holds
    else ready_n_reg <= ((state_reg == host_port_pkg::ST_FALL) && fallBlocked && !strobeRise) ||
                        ((state_reg == host_port_pkg::ST_RISE) && !riseDone);
  end
  assign portReadyN = ready_n_reg;

  // data loads on the same edge that releases ready
  always_ff @(posedge clk_sys) begin
    if (!rst_n) dataOut_reg <= '0;
    else if (fallAct && isRead) dataOut_reg <= readHalf;
  end
  assign hostDataOut = dataOut_reg;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) dataOe_reg <= 1'b0;
    else if (strobeRise || csSyncN) dataOe_reg <= 1'b0;
    else if (fallAct && isRead) dataOe_reg <= 1'b1;
  end
  assign hostDataOe = dataOe_reg;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) readWord_reg <= '0;
    else if (fallAct && isRead && isFirst && sel_reg == host_port_pkg::SEL_DATA_INC) readWord_reg <= rdFifoData;
    else if (fallAct && isRead && isFirst && sel_reg == host_port_pkg::SEL_DATA_FIX) readWord_reg <= memRdData;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) firstHalf_reg <= '0;
    else if (commit && isData && isFirst) firstHalf_reg <= wrHalf_reg;
  end

  // word held in flops while the write FIFO accepts it
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      memWrData <= '0;
      memWrAddr <= ADDR_ZERO();
    end else if (state_reg == host_port_pkg::ST_HOLD && strobeRise && isData && !isFirst) begin
      memWrData <= {dataSync, firstHalf_reg};
      memWrAddr <= writeAddr_reg;
    end
  end

  function automatic logic [WORD_W-1:0] ADDR_ZERO();
    ADDR_ZERO = host_port_pkg::ADDR_RESET;
  endfunction

  always_ff @(posedge clk_sys) begin
    if (!rst_n) pushed_reg <= 1'b0;
    else if (state_reg == host_port_pkg::ST_IDLE) pushed_reg <= 1'b0;
    else if (memWrValid) pushed_reg <= 1'b1;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) ctrl_reg <= host_port_pkg::CTRL_RESET;
    else if (commit && sel_reg == host_port_pkg::SEL_CTRL && isFirst)
      ctrl_reg <= wrHalf_reg & host_port_pkg::CTRL_STORE_MASK;
  end

  // read_command_a bit acts as a command and is never stored
  always_ff @(posedge clk_sys) begin
    if (!rst_n) read_command_a_reg <= 1'b0;
    else read_command_a_reg <= commit && sel_reg == host_port_pkg::SEL_CTRL && isFirst &&
                         wrHalf_reg[host_port_pkg::CTRL_READ_COMMAND_A_BIT];
  end
  assign prefetchReq = read_command_a_reg;

  // set wins over the clear
  always_ff @(posedge clk_sys) begin
    if (!rst_n) prefetchBusy_reg <= 1'b0;
    else if (read_command_a_reg) prefetchBusy_reg <= 1'b1;
    else if (rdFifoValid) prefetchBusy_reg <= 1'b0;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) settle_reg <= '0;
    else if (commit && sel_reg == host_port_pkg::SEL_ADDR)
      settle_reg <= host_port_pkg::SETTLE_W'(host_port_pkg::ADDR_SETTLE_CYCLES);
    else if (settleBusy) settle_reg <= settle_reg - 1'b1;
  end

  // write address, shared with reads in single mode
  always_ff @(posedge clk_sys) begin
    if (!rst_n) writeAddr_reg <= host_port_pkg::ADDR_RESET;
    else if (commit && sel_reg == host_port_pkg::SEL_ADDR)
      writeAddr_reg <= setHalf(writeAddr_reg, isFirst, wrHalf_reg);
    else if (commit && sel_reg == host_port_pkg::SEL_DATA_INC && !isFirst)
      writeAddr_reg <= writeAddr_reg + host_port_pkg::ADDR_STEP;
    else if (!dualAddrMode && fallAct && isRead && !isFirst && sel_reg == host_port_pkg::SEL_DATA_INC)
      writeAddr_reg <= writeAddr_reg + host_port_pkg::ADDR_STEP;
  end

  // read address, follows writes unless dual mode
  always_ff @(posedge clk_sys) begin
    if (!rst_n) readAddr_reg <= host_port_pkg::ADDR_RESET;
    else if (commit && sel_reg == host_port_pkg::SEL_ADDR && !dualAddrMode)
      readAddr_reg <= setHalf(readAddr_reg, isFirst, wrHalf_reg);
    else if (!dualAddrMode && commit && sel_reg == host_port_pkg::SEL_DATA_INC && !isFirst)
      readAddr_reg <= readAddr_reg + host_port_pkg::ADDR_STEP;
    else if (fallAct && isRead && !isFirst && sel_reg == host_port_pkg::SEL_DATA_INC)
      readAddr_reg <= readAddr_reg + host_port_pkg::ADDR_STEP;
  end
  assign memRdAddr = readAddr_reg;

endmodule // host_port_strobe_handshake
`default_nettype wire

// [test/host_port_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module host_port_host_model (
  input wire logic clk_sys, // system clock
  input wire logic portReadyN, // ready from device
  input wire logic [15:0] hostDataOut, // device read data
  input wire logic hostDataOe, // device drives bus
  output logic portSelectN, // chip select
  output logic dataStrobeAN, // strobe a
  output logic dataStrobeBN, // strobe b
  output logic [1:0] registerSelect, // register select
  output logic hostReadWrite, // high reads
  output logic halfwordIdentifier, // half-word id
  output logic [15:0] hostDataIn // bus level seen by device
);
  logic [15:0] drive = 16'h0000;
  // bus level resolved from both drivers
  assign hostDataIn = hostDataOe ? hostDataOut : drive;
  initial begin
    portSelectN = 1'b1;
    dataStrobeAN = 1'b1;
    dataStrobeBN = 1'b1;
    registerSelect = 2'h0;
    hostReadWrite = 1'b1;
    halfwordIdentifier = 1'b0;
  end
  task automatic access(input logic [1:0] sel, input logic rw, input logic hw, input logic [15:0] wdata,
    output logic [15:0] rdata);
    @(negedge clk_sys);
    // selects set a cycle ahead, held all access
    registerSelect = sel;
    hostReadWrite = rw;
    halfwordIdentifier = hw;
    // a released bus shows no stale value
    drive = rw ? ~drive : wdata;
    @(negedge clk_sys);
    portSelectN = 1'b0;
    dataStrobeAN = hw;
    dataStrobeBN = !hw;
    repeat (6) @(negedge clk_sys);
    while (portReadyN !== 1'b0) @(negedge clk_sys);
    rdata = hostDataOut;
    dataStrobeAN = 1'b1;
    dataStrobeBN = 1'b1;
    repeat (5) @(negedge clk_sys);
    drive = ~drive;
    while (portReadyN !== 1'b0) @(negedge clk_sys);
    portSelectN = 1'b1;
    repeat (4) @(negedge clk_sys);
  endtask
endmodule // host_port_host_model
`default_nettype wire

// [test/host_port_strobe_handshake_checker.sv]
`timescale 1ns/1ps
`default_nettype none
module host_port_strobe_handshake_checker (
  input wire logic clk_sys, // system clock
  input wire logic rst_n, // reset, active low
  input wire logic portSelectN, // chip select
  input wire logic dataStrobeAN, // strobe a
  input wire logic dataStrobeBN, // strobe b
  input wire logic [1:0] registerSelect, // register select
  input wire logic hostReadWrite, // high reads
  input wire logic halfwordIdentifier, // half-word id
  input wire logic hostDataOe, // bus drive enable
  input wire logic portReadyN, // ready, active low
  input wire logic memWrValid, // word offered
  input wire logic wrFifoFull, // write fifo full
  input wire logic memRdReq, // fetch request
  input wire logic rdFifoValid, // read fifo has word
  input wire logic rdFifoPop // read fifo pop
);
  logic strobeOn;
  // pin-level strobe; margins below cover the two-flop sync delay
  assign strobeOn = !portSelectN && (dataStrobeAN != dataStrobeBN);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  chk_strobe_idle_oe: assert property ((!strobeOn)[*5] |-> !hostDataOe)
    else $error("bus driven while strobe inactive");
  chk_deselect_ready: assert property (portSelectN[*5] |-> !portReadyN)
    else $error("ready not low while deselected");
  chk_ready_data: assert property ($fell(portReadyN) && hostReadWrite && !portSelectN |-> hostDataOe)
    else $error("ready before read data");
  chk_reg_read_nostall: assert property ((strobeOn && hostReadWrite && registerSelect[1] == 1'b0)[*4]
    |-> !portReadyN)
    else $error("control or address read stalled");
  // ready is registered, so it rises one cycle after the fetch starts
  chk_fetch_stall: assert property (memRdReq && $past(memRdReq) |-> portReadyN)
    else $error("ready low during fetch");
  chk_full_gate: assert property (memWrValid |-> !wrFifoFull)
    else $error("push while fifo full");
  chk_push_pulse: assert property (memWrValid |=> !memWrValid)
    else $error("push longer than one cycle");
  chk_full_stall: assert property ((strobeOn && !hostReadWrite && wrFifoFull
    && registerSelect == host_port_pkg::SEL_DATA_INC)[*6] |-> portReadyN)
    else $error("no stall on full fifo");
  chk_pop_valid: assert property (rdFifoPop |-> rdFifoValid)
    else $error("pop from empty fifo");
  chk_inc_second_half: assert property ((strobeOn && hostReadWrite && halfwordIdentifier
    && registerSelect == host_port_pkg::SEL_DATA_INC)[*6] |-> !portReadyN)
    else $error("second half stalled");
  chk_fix_second_half: assert property ((strobeOn && hostReadWrite && halfwordIdentifier
    && registerSelect == host_port_pkg::SEL_DATA_FIX)[*6] |-> !portReadyN)
    else $error("fixed second half stalled");
  chk_inc_data_ready: assert property ((strobeOn && hostReadWrite && rdFifoValid
    && registerSelect == host_port_pkg::SEL_DATA_INC)[*6] |-> !portReadyN)
    else $error("stall with data present");
endmodule // host_port_strobe_handshake_checker
`default_nettype wire

// [test/host_port_strobe_handshake_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module host_port_strobe_handshake_tb;
  logic clk_sys, rst_n, portSelectN, dataStrobeAN, dataStrobeBN, hostReadWrite, halfwordIdentifier;
  logic [1:0] registerSelect;
  logic [15:0] hostDataIn, hostDataOut, rd;
  logic hostDataOe, portReadyN, memWrValid, wrFifoFull, wrFifoFlushing, wrFifoEmpty;
  logic memRdReq, rdFifoValid, rdFifoPop, prefetchReq, dualAddrMode;
  logic memRdAck = 1'b0;
  logic [31:0] memWrAddr, memWrData, memRdAddr, memRdData, rdFifoData, pushData, pushAddr;
  int errorCnt = 0, checkCount = 0, cycles = 0, fetchWait = 0, pops = 0, pushes = 0, prefetches = 0;

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  host_port_host_model host_u (.clk_sys(clk_sys), .portReadyN(portReadyN), .hostDataOut(hostDataOut),
    .hostDataOe(hostDataOe), .portSelectN(portSelectN), .dataStrobeAN(dataStrobeAN),
    .dataStrobeBN(dataStrobeBN), .registerSelect(registerSelect), .hostReadWrite(hostReadWrite),
    .halfwordIdentifier(halfwordIdentifier), .hostDataIn(hostDataIn));

  host_port_strobe_handshake dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .portSelectN(portSelectN),
    .dataStrobeAN(dataStrobeAN), .dataStrobeBN(dataStrobeBN), .registerSelect(registerSelect),
    .hostReadWrite(hostReadWrite), .halfwordIdentifier(halfwordIdentifier), .hostDataIn(hostDataIn),
    .hostDataOut(hostDataOut), .hostDataOe(hostDataOe), .portReadyN(portReadyN), .memWrValid(memWrValid),
    .memWrAddr(memWrAddr), .memWrData(memWrData), .wrFifoFull(wrFifoFull), .wrFifoFlushing(wrFifoFlushing),
    .wrFifoEmpty(wrFifoEmpty), .memRdReq(memRdReq), .memRdAddr(memRdAddr), .memRdAck(memRdAck),
    .memRdData(memRdData), .rdFifoValid(rdFifoValid), .rdFifoData(rdFifoData), .rdFifoPop(rdFifoPop),
    .prefetchReq(prefetchReq), .dualAddrMode(dualAddrMode));

  // memory answers a fetch after a few cycles
  always @(negedge clk_sys) begin
    memRdAck <= 1'b0;
    if (memRdReq === 1'b1 && !memRdAck) begin
      fetchWait <= fetchWait + 1;
      if (fetchWait == 3) begin
        memRdAck <= 1'b1;
        fetchWait <= 0;
      end
    end
  end

  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (memWrValid === 1'b1) begin
      pushes <= pushes + 1;
      pushData <= memWrData;
      pushAddr <= memWrAddr;
    end
    if (rdFifoPop === 1'b1) pops <= pops + 1;
    if (prefetchReq === 1'b1) prefetches <= prefetches + 1;
    if (cycles == 4000) begin
      errorCnt++;
      report_and_stop();
    end
  end

  task check(input logic [31:0] got, input logic [31:0] exp);
    checkCount++;
    if (got !== exp) begin
      errorCnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task report_and_stop();
    if (errorCnt == 0 && checkCount > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task t_ctrl();
    host_u.access(host_port_pkg::SEL_CTRL, 1'b0, 1'b0, 16'h0008, rd);
    check(dualAddrMode, 32'h1);
    host_u.access(host_port_pkg::SEL_CTRL, 1'b1, 1'b0, 16'h0000, rd);
    check(rd, 32'h0008);
    host_u.access(host_port_pkg::SEL_CTRL, 1'b1, 1'b1, 16'h0000, rd);
    check(rd, 32'h0000);
    host_u.access(host_port_pkg::SEL_CTRL, 1'b0, 1'b0, 16'h0000, rd);
    check(dualAddrMode, 32'h0);
    // read_command_a command pulses once and is not stored
    host_u.access(host_port_pkg::SEL_CTRL, 1'b0, 1'b0, 16'h0010, rd);
    check(prefetches, 32'h1);
    host_u.access(host_port_pkg::SEL_CTRL, 1'b1, 1'b0, 16'h0000, rd);
    check(rd, 32'h0000);
    // address write after read_command_a waits for the read fifo
    fork
      host_u.access(host_port_pkg::SEL_ADDR, 1'b0, 1'b0, 16'h0000, rd);
      begin
        repeat (12) @(negedge clk_sys);
        check(portReadyN, 32'h1);
        rdFifoValid = 1'b1;
      end
    join
    rdFifoValid = 1'b0;
  endtask

  task t_addr();
    host_u.access(host_port_pkg::SEL_ADDR, 1'b0, 1'b0, 16'h1234, rd);
    host_u.access(host_port_pkg::SEL_ADDR, 1'b0, 1'b1, 16'h0000, rd);
    check(memRdAddr, 32'h0000_1234);
    host_u.access(host_port_pkg::SEL_ADDR, 1'b1, 1'b0, 16'h0000, rd);
    check(rd, 32'h1234);
  endtask

  task t_wr();
    host_u.access(host_port_pkg::SEL_DATA_INC, 1'b0, 1'b0, 16'hBEEF, rd);
    host_u.access(host_port_pkg::SEL_DATA_INC, 1'b0, 1'b1, 16'hCAFE, rd);
    check(pushData, 32'hCAFE_BEEF);
    check(pushAddr, 32'h0000_1234);
  endtask

  task t_full();
    wrFifoFull = 1'b1;
    fork
      host_u.access(host_port_pkg::SEL_DATA_INC, 1'b0, 1'b0, 16'h1111, rd);
      begin
        repeat (12) @(negedge clk_sys);
        check(portReadyN, 32'h1);
        wrFifoFull = 1'b0;
      end
    join
    host_u.access(host_port_pkg::SEL_DATA_INC, 1'b0, 1'b1, 16'h2222, rd);
    check(pushes, 32'h2);
    check(pushData, 32'h2222_1111);
    check(pushAddr, 32'h0000_1238);
  endtask

  task t_rdfix();
    host_u.access(host_port_pkg::SEL_DATA_FIX, 1'b1, 1'b0, 16'h0000, rd);
    check(rd, 32'h4567);
    check(memRdAddr, 32'h0000_123C);
    host_u.access(host_port_pkg::SEL_DATA_FIX, 1'b1, 1'b1, 16'h0000, rd);
    check(rd, 32'h89AB);
  endtask

  task t_rdinc();
    fork
      host_u.access(host_port_pkg::SEL_DATA_INC, 1'b1, 1'b0, 16'h0000, rd);
      begin
        repeat (12) @(negedge clk_sys);
        check(portReadyN, 32'h1);
        rdFifoData = 32'h0F0E_0D0C;
        rdFifoValid = 1'b1;
      end
    join
    check(rd, 32'h0D0C);
    check(pops, 32'h1);
    // second half must come from the popped word, not the next fifo word
    rdFifoData = 32'h5A5A_A5A5;
    host_u.access(host_port_pkg::SEL_DATA_INC, 1'b1, 1'b1, 16'h0000, rd);
    check(rd, 32'h0F0E);
    check(pops, 32'h1);
  endtask

  initial begin
    rst_n = 1'b0;
    wrFifoFull = 1'b0;
    wrFifoFlushing = 1'b0;
    wrFifoEmpty = 1'b1;
    memRdData = 32'h89AB_4567;
    rdFifoValid = 1'b0;
    rdFifoData = 32'h0000_0000;
    repeat (4) @(negedge clk_sys);
    rst_n = 1'b1;
    t_ctrl();
    t_addr();
    t_wr();
    t_full();
    t_rdfix();
    t_rdinc();
    report_and_stop();
  end
endmodule // host_port_strobe_handshake_tb

bind host_port_strobe_handshake host_port_strobe_handshake_checker chk_u (.clk_sys(clk_sys), .rst_n(rst_n),
  .portSelectN(portSelectN), .dataStrobeAN(dataStrobeAN), .dataStrobeBN(dataStrobeBN),
  .registerSelect(registerSelect), .hostReadWrite(hostReadWrite), .halfwordIdentifier(halfwordIdentifier),
  .hostDataOe(hostDataOe), .portReadyN(portReadyN), .memWrValid(memWrValid), .wrFifoFull(wrFifoFull),
  .memRdReq(memRdReq), .rdFifoValid(rdFifoValid), .rdFifoPop(rdFifoPop));
`default_nettype wire
